// file: rtl/uatx_top.sv
/*
 * serial transceiver with 8/9-bit frames and multi-processor filtering,
 * register file on apb. assumes apb master keeps the request steady
 * until pready; pins are plain synchronous levels.
 */
// The APB slave port is this design's own decision.
// Operation
// - idle transmitter loads shifter on write at once
// - busy transmitter loads after stop bit leaves
// - transfer sets empty flag, start, stop bits
// - nine-bit mode copies ninth bit to shifter
// - start then data lsb first then stop
// - empty flag stays set until next write
// - full stop bit without new data sets complete
// - transmitter enable forces output pin driven
// - receiver samples at sixteen times baud
// - one low idle sample starts start detection
// - two high of samples 8-10 reject start
// - data bits take majority of three samples
// - low stop majority sets framing error
// - frame end moves character, sets receive complete
// - data port reads receive, writes transmit
// - nine-bit mode stores received ninth bit
// - unread character drops new one, overrun buffered
// - receiver enable forces input, pull-up kept
// - address frames marked by high stop/ninth bit
// - filter mode discards data frames silently
// - reading data clears receive complete; irq request
// - vector or written one clears transmit complete
// - data write clears empty flag, set at reset
// - baud is clock over sixteen times divider+1
`timescale 1ns/10ps
module uatx_top (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [uatx_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic rxd_in, // serial input pin level
    input wire logic txc_vector_taken, // tx complete vector taken
    input wire logic pin_one_direction, // gpio direction, tx pin
    input wire logic port_pin_one, // gpio output value, tx pin
    input wire logic pin_zero_direction, // gpio direction, rx pin
    input wire logic pin_zero_output_bit, // gpio value / pull-up, rx pin
    output logic txd_out, // tx pin output value
    output logic txd_oe, // tx pin output enable
    output logic rxd_oe, // rx pin output enable
    output logic rxd_out, // rx pin output value in gpio use
    output logic rxd_pullup, // rx pin pull-up enable
    output logic rx_irq, // receive complete request
    output logic tx_irq, // transmit complete request
    output logic tx_buffer_empty_flag_irq // data buffer empty request
);
    import uatx_pkg::*;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } uatx_tx_t;

    ////////////////////////////////////////////////////////////////////
    // register state
    ////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_ff;
    logic [BAUD_W-1:0] baud_ff;
    logic multiproc_filter_mode_ff;
    logic rxc_ff;
    logic txc_ff;
    logic tx_buffer_empty_flag_ff;
    logic fe_ff;
    logic ovr_ff;
    logic ovr_pend_ff;
    logic rx_ninth_bit_ff;
    logic [7:0] rdr_ff;
    logic [7:0] tdr_ff;

    wire receiver_enable = ctrl_ff[CB_RECEIVER_ENABLE];
    wire transmitter_enable = ctrl_ff[CB_TRANSMITTER_ENABLE];
    wire nine_bit_select = ctrl_ff[CB_NINE_BIT_SELECT];

    ////////////////////////////////////////////////////////////////////
    // apb decode: setup edge raises pready, access edge completes
    ////////////////////////////////////////////////////////////////////
    wire [ADDR_W-1:0] a_baud = {2'b00, IDX_BAUD, 2'b00};
    wire [ADDR_W-1:0] a_ctrl = {2'b00, IDX_CTRL_B, 2'b00};
    wire [ADDR_W-1:0] a_stat = {2'b00, IDX_STAT_A, 2'b00};
    wire [ADDR_W-1:0] a_data = {2'b00, IDX_DATA, 2'b00};
    wire hit_baud = (paddr == a_baud);
    wire hit_ctrl = (paddr == a_ctrl);
    wire hit_stat = (paddr == a_stat);
    wire hit_data = (paddr == a_data);
    wire mapped = hit_baud | hit_ctrl | hit_stat | hit_data;
    wire setup = psel & ~penable;
    wire done_acc = psel & penable & pready;
    wire wr = done_acc & pwrite & mapped;
    wire rd = done_acc & ~pwrite & mapped;
    wire wr_data = wr & hit_data;
    wire rd_data = rd & hit_data;
    wire wr_stat = wr & hit_stat;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_baud = wr & hit_baud;

    wire [7:0] stat_view = {rxc_ff, txc_ff, tx_buffer_empty_flag_ff, fe_ff, ovr_ff,
                            2'b00, multiproc_filter_mode_ff};
    wire [7:0] ctrl_view = {ctrl_ff[7:2], rx_ninth_bit_ff, ctrl_ff[CB_TX_NINTH_BIT]};
    wire [31:0] rd_mux = hit_data ? {24'h000000, rdr_ff} :
                         hit_stat ? {24'h000000, stat_view} :
                         hit_ctrl ? {24'h000000, ctrl_view} :
                         hit_baud ? {20'h00000, baud_ff} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // baud generator and bit-rate divider for the transmitter
    ////////////////////////////////////////////////////////////////////
    logic tick16;
    logic [3:0] tx_pre_ff;

    uatx_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divider(baud_ff),
        .tick16(tick16)
    );

    wire tx_tick = tick16 & (tx_pre_ff == OVS_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pre_ff <= 4'h0;
        end else if (tick16) begin
            tx_pre_ff <= tx_pre_ff + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and baud registers
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CB_RESET;
            baud_ff <= BAUD_RESET;
            multiproc_filter_mode_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[7:0];
            end
            if (wr_baud) begin
                baud_ff <= pwdata[BAUD_W-1:0];
            end
            if (wr_stat) begin
                multiproc_filter_mode_ff <= pwdata[SA_MULTIPROC_FILTER_MODE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter
    ////////////////////////////////////////////////////////////////////
    uatx_tx_t tx_st_ff;
    logic [10:0] tsh_ff;
    logic [3:0] tleft_ff;
    logic tx_line_ff;

    wire pending = ~tx_buffer_empty_flag_ff;
    wire stop_done = (tx_st_ff == TX_SHIFT) & tx_tick & (tleft_ff == 4'h0);
    wire idle_load = (tx_st_ff == TX_IDLE) & pending & transmitter_enable;
    wire chain_load = stop_done & pending;
    wire tx_load = idle_load | chain_load;
    wire tx_finish = stop_done & ~pending;
    wire [3:0] frame_len = nine_bit_select ? FRAME_9 : FRAME_8;
    // start bit low, stop bit high, ninth bit at position 9
    wire [10:0] frame = nine_bit_select ? {1'b1, ctrl_ff[CB_TX_NINTH_BIT], tdr_ff, 1'b0} :
                               {1'b1, 1'b1, tdr_ff, 1'b0};
    wire tx_drive = (tx_st_ff == TX_SHIFT) & tx_tick & (tleft_ff != 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_ff <= TX_IDLE;
            tsh_ff <= 11'h7ff;
            tleft_ff <= 4'h0;
            tx_line_ff <= 1'b1;
        end else begin
            if (tx_load) begin
                tx_st_ff <= TX_SHIFT;
                tsh_ff <= frame;
                tleft_ff <= frame_len;
            end else if (tx_finish) begin
                tx_st_ff <= TX_IDLE;
            end else if (tx_drive) begin
                tx_line_ff <= tsh_ff[0];
                tsh_ff <= {1'b1, tsh_ff[10:1]};
                tleft_ff <= tleft_ff - 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdr_ff <= 8'h00;
            tx_buffer_empty_flag_ff <= SA_RESET[SA_TX_BUFFER_EMPTY_FLAG];
            txc_ff <= SA_RESET[SA_TXC];
        end else begin
            if (wr_data) begin
                tdr_ff <= pwdata[7:0];
                tx_buffer_empty_flag_ff <= 1'b0;
            end else if (tx_load) begin
                tx_buffer_empty_flag_ff <= 1'b1;
            end
            // a finishing frame wins over a clear in the same cycle
            if (tx_finish) begin
                txc_ff <= 1'b1;
            end else if (txc_vector_taken | (wr_stat & pwdata[SA_TXC])) begin
                txc_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receiver
    ////////////////////////////////////////////////////////////////////
    logic rx_done;
    logic [8:0] rx_data;
    logic rx_stop;

    uatx_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .enable(receiver_enable),
        .nine(nine_bit_select),
        .tick16(tick16),
        .rxd(rxd_in),
        .done(rx_done),
        .data(rx_data),
        .stop_bit(rx_stop)
    );

    wire ninth = nine_bit_select & rx_data[8];
    wire is_addr = nine_bit_select ? rx_data[8] : rx_stop;
    wire keep = rx_done & (~multiproc_filter_mode_ff | is_addr);
    wire rxc_held = rxc_ff & ~rd_data;
    wire accept = keep & ~rxc_held;
    wire overrun = keep & rxc_held;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdr_ff <= 8'h00;
            rx_ninth_bit_ff <= 1'b0;
            rxc_ff <= SA_RESET[SA_RXC];
            fe_ff <= SA_RESET[SA_FE];
            ovr_ff <= SA_RESET[SA_OVR];
            ovr_pend_ff <= 1'b0;
        end else begin
            if (accept) begin
                rdr_ff <= rx_data[7:0];
                rx_ninth_bit_ff <= ninth;
                rxc_ff <= 1'b1;
                fe_ff <= ~rx_stop;
                ovr_ff <= 1'b0;
            end else if (rd_data) begin
                rxc_ff <= 1'b0;
                ovr_ff <= ovr_pend_ff | overrun;
            end
            if (rd_data) begin
                ovr_pend_ff <= 1'b0;
            end else if (overrun) begin
                ovr_pend_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pins and interrupt requests
    ////////////////////////////////////////////////////////////////////
    // transmitter keeps the pin until its frame and pending byte are out
    wire tx_owns = transmitter_enable | (tx_st_ff == TX_SHIFT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_out <= 1'b0;
            txd_oe <= 1'b0;
            rxd_oe <= 1'b0;
            rxd_out <= 1'b0;
            rxd_pullup <= 1'b0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            tx_buffer_empty_flag_irq <= 1'b0;
        end else begin
            txd_out <= tx_owns ? tx_line_ff : port_pin_one;
            txd_oe <= tx_owns | pin_one_direction;
            rxd_oe <= ~receiver_enable & pin_zero_direction;
            rxd_out <= pin_zero_output_bit;
            rxd_pullup <= (receiver_enable | ~pin_zero_direction)
                          & pin_zero_output_bit;
            rx_irq <= rxc_ff & ctrl_ff[CB_RX_COMPLETE_IRQ_ENABLE];
            tx_irq <= txc_ff & ctrl_ff[CB_TX_COMPLETE_IRQ_ENABLE];
            tx_buffer_empty_flag_irq <= tx_buffer_empty_flag_ff & ctrl_ff[CB_UDRIE];
        end
    end
endmodule : uatx_top

// file: rtl/uatx_pkg.sv
/*
 * constants for the serial transceiver: register indices, bit fields,
 * reset values and frame lengths. assumes a 32-bit apb register bus.
 */
package uatx_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BAUD = 8'h09;
    localparam logic [7:0] IDX_CTRL_B = 8'h0a;
    localparam logic [7:0] IDX_STAT_A = 8'h0b;
    localparam logic [7:0] IDX_DATA = 8'h0c;
    localparam int ADDR_W = 12;
    // status_a fields
    localparam int SA_RXC = 7;
    localparam int SA_TXC = 6;
    localparam int SA_TX_BUFFER_EMPTY_FLAG = 5;
    localparam int SA_FE = 4;
    localparam int SA_OVR = 3;
    localparam int SA_MULTIPROC_FILTER_MODE = 0;
    localparam logic [7:0] SA_RESET = 8'h20;
    // control_b fields
    localparam int CB_RX_COMPLETE_IRQ_ENABLE = 7;
    localparam int CB_TX_COMPLETE_IRQ_ENABLE = 6;
    localparam int CB_UDRIE = 5;
    localparam int CB_RECEIVER_ENABLE = 4;
    localparam int CB_TRANSMITTER_ENABLE = 3;
    localparam int CB_NINE_BIT_SELECT = 2;
    localparam int CB_RX_NINTH_BIT = 1;
    localparam int CB_TX_NINTH_BIT = 0;
    localparam logic [7:0] CB_RESET = 8'h00;
    // baud divider
    localparam int BAUD_W = 12;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    // oversampling and frames
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SMP_A = 4'h8;
    localparam logic [3:0] SMP_B = 4'h9;
    localparam logic [3:0] SMP_C = 4'ha;
    localparam logic [3:0] FRAME_8 = 4'ha;
    localparam logic [3:0] FRAME_9 = 4'hb;
    localparam logic [3:0] DATA_8 = 4'h8;
    localparam logic [3:0] DATA_9 = 4'h9;
endpackage : uatx_pkg

// file: rtl/uatx_baud.sv
/*
 * baud generator: one pulse per oversampling period, sixteen per bit.
 * assumes the divider value is held stable by software while in use.
 */
`timescale 1ns/10ps
module uatx_baud (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [uatx_pkg::BAUD_W-1:0] divider, // divider value
    output logic tick16 // oversampling pulse
);
    import uatx_pkg::*;

    logic [BAUD_W-1:0] cnt_ff;
    logic [BAUD_W-1:0] nxt_cnt;
    wire at_zero = (cnt_ff == '0);

    // period of divider+1 clocks, so bit = 16*(divider+1)
    assign nxt_cnt = at_zero ? divider : cnt_ff - 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= BAUD_RESET;
            tick16 <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick16 <= at_zero;
        end
    end
endmodule : uatx_baud

// file: rtl/uatx_rx.sv
/*
 * receive front end: 16x oversampling, start validation and majority
 * vote over samples 8, 9 and 10 of every bit. assumes rxd is synchronous.
 */
`timescale 1ns/10ps
module uatx_rx (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic enable, // receiver enabled
    input wire logic nine, // nine data bits
    input wire logic tick16, // oversampling pulse
    input wire logic rxd, // serial input
    output logic done, // one-cycle pulse at end of frame
    output logic [8:0] data, // data bits, lsb in bit 0
    output logic stop_bit // voted stop bit
);
    import uatx_pkg::*;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } uatx_rx_t;

    function automatic logic maj3(input logic a, b, c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    uatx_rx_t st_ff;
    logic [3:0] smp_ff;
    logic [3:0] bit_ff;
    logic [1:0] vote_ff;
    logic [8:0] sh_ff;
    wire is_vote = (smp_ff == SMP_A) || (smp_ff == SMP_B);
    wire is_decide = (smp_ff == SMP_C);
    wire bit_val = maj3(vote_ff[1], vote_ff[0], rxd);
    wire [3:0] nbits = nine ? DATA_9 : DATA_8;
    wire [8:0] sh_in = {bit_val, sh_ff[8:1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= RX_IDLE;
            smp_ff <= 4'h0;
            bit_ff <= 4'h0;
            vote_ff <= 2'b00;
            sh_ff <= 9'h000;
            done <= 1'b0;
            data <= 9'h000;
            stop_bit <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!enable) begin
                st_ff <= RX_IDLE;
            end else if (tick16) begin
                smp_ff <= smp_ff + 4'h1;
                if (is_vote) begin
                    vote_ff <= {vote_ff[0], rxd};
                end
                unique case (st_ff)
                    RX_IDLE: begin
                        if (!rxd) begin
                            st_ff <= RX_START;
                            smp_ff <= 4'h2;
                        end
                    end
                    RX_START: begin
                        if (is_decide) begin
                            st_ff <= bit_val ? RX_IDLE : RX_BITS;
                            bit_ff <= 4'h0;
                        end
                    end
                    RX_BITS: begin
                        if (is_decide && bit_ff == nbits) begin
                            st_ff <= RX_IDLE;
                            done <= 1'b1;
                            stop_bit <= bit_val;
                            data <= nine ? sh_ff : {1'b0, sh_ff[8:1]};
                        end else if (is_decide) begin
                            sh_ff <= sh_in;
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end
                    default: st_ff <= RX_IDLE;
                endcase
            end
        end
    end
endmodule : uatx_rx

// file: dv/uatx_assertions.sv
/*
 * port checker for uatx_top: apb timing, pin ownership, requests.
 * assumes it is bound to uatx_top from the testbench top file.
 */
`timescale 1ns/10ps
module uatx_checker (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [uatx_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic txd_oe, // tx pin enable
    input wire logic rxd_oe, // rx pin enable
    input wire logic rx_irq, // receive request
    input wire logic tx_irq // transmit request
);
    import uatx_pkg::*;
    localparam logic [11:0] A_BAUD = {2'b00, IDX_BAUD, 2'b00};
    localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_STAT_A, 2'b00};
    localparam logic [11:0] A_DATA = {2'b00, IDX_DATA, 2'b00};
    logic [7:0] ctrl_ff;
    wire setup = psel && !penable;
    wire rd_setup = setup && !pwrite;
    wire mapped = paddr == A_BAUD || paddr == A_CTRL ||
        paddr == A_STAT || paddr == A_DATA;
    wire ctrl_wr = psel && penable && pready && pwrite && paddr == A_CTRL;
    wire [7:0] nxt_ctrl = ctrl_wr ? pwdata[7:0] : ctrl_ff;

    // shadow of control_b as written over apb
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CB_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (setup && !mapped |=>
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    status_resv_a: assert property (rd_setup && paddr == A_STAT |=>
        prdata[31:8] == 24'h0 && prdata[2:1] == 2'b00)
        else $error("status reserved bits set");
    data_width_a: assert property (
        rd_setup && paddr == A_DATA |=> prdata[31:9] == 23'h0)
        else $error("data port upper bits set");
    tx_pin_a: assert property (
        ctrl_ff[CB_TRANSMITTER_ENABLE] && $past(ctrl_ff[CB_TRANSMITTER_ENABLE], 2) |-> txd_oe)
        else $error("tx pin not driven");
    rx_pin_a: assert property (
        ctrl_ff[CB_RECEIVER_ENABLE] && $past(ctrl_ff[CB_RECEIVER_ENABLE], 2) |-> !rxd_oe)
        else $error("rx pin not input");
    rx_req_a: assert property (rx_irq |->
        ctrl_ff[CB_RX_COMPLETE_IRQ_ENABLE] || $past(ctrl_ff[CB_RX_COMPLETE_IRQ_ENABLE]))
        else $error("rx request without enable");
    tx_req_a: assert property (tx_irq |->
        ctrl_ff[CB_TX_COMPLETE_IRQ_ENABLE] || $past(ctrl_ff[CB_TX_COMPLETE_IRQ_ENABLE]))
        else $error("tx request without enable");
endmodule : uatx_checker

// file: dv/uatx_peer.sv
/*
 * remote serial transceiver: captures frames from the line into a
 * queue and sends frames on request. assumes idle-high lines.
 */
`timescale 1ns/10ps
module uatx_peer (
    input wire logic pclk, // system clock
    input wire logic txd, // line from the transceiver
    input wire logic txd_oe, // transceiver owns its line
    input wire logic [7:0] bit_clks, // clocks per bit
    input wire logic [3:0] frame_bits, // start to stop inclusive
    output logic rxd // line to the transceiver
);
    logic [10:0] got_q[$];
    logic [10:0] f;

    // capture, sampling mid-bit
    initial begin
        rxd = 1'b1;
        forever begin
            @(posedge pclk);
            if (txd_oe === 1'b1 && txd === 1'b0) begin
                f = '0;
                repeat (bit_clks / 2) @(posedge pclk);
                for (int i = 0; i < int'(frame_bits); i++) begin
                    f[i] = txd;
                    if (i < int'(frame_bits) - 1) begin
                        repeat (bit_clks) @(posedge pclk);
                    end
                end
                got_q.push_back(f);
            end
        end
    end

    task send(input logic [10:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= fr[i];
            repeat (bit_clks) @(posedge pclk);
        end
        rxd <= 1'b1;
        @(posedge pclk);
    endtask : send

    // short low spike, then one idle bit
    task glitch(input int n);
        rxd <= 1'b0;
        repeat (n) @(posedge pclk);
        rxd <= 1'b1;
        repeat (bit_clks) @(posedge pclk);
    endtask : glitch
endmodule : uatx_peer

// file: dv/uatx_tb.sv
/*
 * testbench for uatx_top: apb tasks and scenario sequence.
 * assumes the remote peer model and the port checker.
 */
`timescale 1ns/10ps
module testbench;
    import uatx_pkg::*;
    localparam logic [11:0] A_BAUD = {2'b00, IDX_BAUD, 2'b00};
    localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_STAT_A, 2'b00};
    localparam logic [11:0] A_DATA = {2'b00, IDX_DATA, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic txc_vector_taken, pin_one_direction, port_pin_one;
    logic pin_zero_direction, pin_zero_output_bit, rxd_in;
    logic txd_out, txd_oe, rxd_oe, rxd_out, rxd_pullup;
    logic rx_irq, tx_irq, tx_buffer_empty_flag_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [10:0] fr;
    logic [7:0] bit_clks;
    logic [3:0] frame_bits;
    int failures, num_checks;

    always #20 pclk = ~pclk;

    uatx_top DUT (.*);
    uatx_peer peer (.pclk(pclk), .txd(txd_out), .txd_oe(txd_oe),
        .bit_clks(bit_clks), .frame_bits(frame_bits), .rxd(rxd_in));

////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 32'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cr(input logic [11:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : cr

    task frame(input logic [10:0] e);
        int n;
        n = 0;
        while (peer.got_q.size() == 0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        fr = peer.got_q.size() > 0 ? peer.got_q.pop_front() : 'x;
        chk(32'(fr), 32'(e));
    endtask : frame

    task stop_test;
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        $display("mismatch at %0t: watchdog", $time);
        stop_test();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, txc_vector_taken} = '0;
        {pin_one_direction, port_pin_one} = 2'b01;
        {pin_zero_direction, pin_zero_output_bit} = 2'b11;
        {paddr, pwdata} = '0;
        {failures, num_checks} = '0;
        bit_clks = 8'd16;
        frame_bits = 4'd10;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cr(A_STAT, 32'hffff_ffff, 32'h20);
        cr(A_CTRL, 32'hffff_ffff, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(q, 32'h0);
        chk(32'({txd_oe, rxd_oe, rxd_out}), 32'h3);
        apb(1'b1, A_CTRL, 32'h58);
        repeat (2) @(posedge pclk);
        chk(32'({txd_oe, rxd_oe, rxd_pullup}), 32'h5);
        // back-to-back: second byte waits for first stop bit
        apb(1'b1, A_DATA, 32'ha5);
        apb(1'b1, A_DATA, 32'h3c);
        cr(A_STAT, 32'h20, 32'h0);
        frame(11'h34a);
        frame(11'h278);
        cr(A_STAT, 32'h40, 32'h0);
        repeat (16) @(posedge pclk);
        cr(A_STAT, 32'h60, 32'h60);
        chk(tx_irq, 1'b1);
        apb(1'b1, A_STAT, 32'h40);
        cr(A_STAT, 32'h40, 32'h0);
        apb(1'b1, A_CTRL, 32'h5d);
        frame_bits <= 4'd11;
        apb(1'b1, A_DATA, 32'h5a);
        frame(11'h6b4);
        repeat (30) @(posedge pclk);
        chk(tx_irq, 1'b1);
        txc_vector_taken <= 1'b1;
        @(posedge pclk);
        txc_vector_taken <= 1'b0;
        cr(A_STAT, 32'h40, 32'h0);
        apb(1'b1, A_CTRL, 32'h18);
        frame_bits <= 4'd10;
        bit_clks <= 8'd32;
        apb(1'b1, A_BAUD, 32'h1);
        apb(1'b1, A_DATA, 32'hc3);
        frame(11'h386);
        cr(A_BAUD, 32'hfff, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b1, A_BAUD, 32'h0);
        bit_clks <= 8'd16;
        apb(1'b1, A_CTRL, 32'h98);
        peer.send(11'h32c, 10);
        chk(rx_irq, 1'b1);
        cr(A_STAT, 32'hb8, 32'ha0);
        cr(A_DATA, 32'hffff_ffff, 32'h96);
        cr(A_STAT, 32'h80, 32'h0);
        peer.glitch(4);
        peer.send(11'h078, 10);
        cr(A_STAT, 32'h90, 32'h90);
        cr(A_DATA, 32'hff, 32'h3c);
        repeat (16) @(posedge pclk);
        peer.send(11'h222, 10);
        peer.send(11'h244, 10);
        cr(A_STAT, 32'h98, 32'h80);
        cr(A_DATA, 32'hff, 32'h11);
        cr(A_STAT, 32'h88, 32'h08);
        // filter mode: data frame dropped, address frame kept
        apb(1'b1, A_STAT, 32'h01);
        peer.send(11'h0aa, 10);
        repeat (16) @(posedge pclk);
        cr(A_STAT, 32'h91, 32'h01);
        peer.send(11'h342, 10);
        cr(A_STAT, 32'h81, 32'h81);
        cr(A_DATA, 32'hff, 32'ha1);
        apb(1'b1, A_CTRL, 32'h3c);
        peer.send(11'h4ee, 11);
        peer.send(11'h7c8, 11);
        cr(A_STAT, 32'h80, 32'h80);
        chk(32'(tx_buffer_empty_flag_irq), 32'h1);
        cr(A_CTRL, 32'h2, 32'h2);
        cr(A_DATA, 32'h1ff, 32'he4);
        stop_test();
    end
endmodule : testbench

bind uatx_top uatx_checker checker_i (.*);
